// >>> hdl/gpio_dual_port.sv
// Functional notes
// - each port interrupt enable bit gates its pin interrupt request
// - trigger kind bit set selects edge trigger, clear selects level trigger
// - pin condition sets its flag; writing one clears it, zero leaves it
// - port b interrupt bit 9 serves pin 23, bit 8 serves pin 22
// - direction bit set makes output, clear input; all reset to input
// - input level register reads pin levels, meaningful while pin is input
// - output pin drives its output latch bit level
// - input pin uses output latch bit as interrupt polarity
// - writing one to output clear register clears the latch bit
// - pull-up register holds one bit per port a pin
// - input pin: pull-down/drive bit enables the pull-down resistor
// - output pin: pull-down/drive bit selects 20 mA over 5 mA drive
// - port a uses bits 15..0, port b 23..0 (its interrupt registers 15..0); higher bits read zero
// - set pull-up bit enables pull-up on an input pin, clear disables it
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "gpio_map.svh"

module gpio_dual_port import gpio_pkg::*; #(
  parameter int PORTA_W = 16,
  parameter int PORTB_W = 24
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // register port
  input wire bus_req_t i_bus,
  output logic [31:0] o_rdata,
  // port a pins
  input wire logic [PORTA_W-1:0] i_porta_pin,
  output porta_pins_t o_porta,
  // port b pins
  input wire logic [PORTB_W-1:0] i_portb_pin,
  output portb_pins_t o_portb,
  // interrupts
  output logic o_porta_irq,
  output logic o_portb_irq,
  output logic o_irq
);

  if (PORTA_W != 16 || PORTB_W != 24) begin : g_width_check
    $error("gpio_dual_port serves only 16 port a and 24 port b pins");
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // a bit moves once the second and third stages agree
  function automatic logic [23:0] settle(input logic [23:0] s2, input logic [23:0] s3,
                                         input logic [23:0] lvl);
    settle = (s2 & s3) | (lvl & (s2 | s3));
  endfunction

  function automatic logic [15:0] fold(input logic [23:0] x);
    fold = {x[15:10], x[`PORTB_FOLD_HI_PIN], x[`PORTB_FOLD_LO_PIN], x[7:0]};
  endfunction

  function automatic logic [15:0] detect(input logic [15:0] lvl, input logic [15:0] prev,
                                         input logic [15:0] pol, input logic [15:0] trig,
                                         input logic [15:0] dir);
    logic [15:0] act;
    logic [15:0] pact;
    act = (pol & lvl) | (~pol & ~lvl);
    pact = (pol & prev) | (~pol & ~prev);
    detect = act & ~(trig & pact) & ~dir;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  state_t st_r;
  state_t st_nxt;
  logic [15:0] cond_a;
  logic [15:0] cond_b;
  logic [15:0] wclr_a;
  logic [15:0] wclr_b;
  logic [1:0] evt;
  logic wr_hit;
  logic [23:0] a_settled;

  always_comb begin
    st_nxt = st_r;
    // input synchronisers
    st_nxt.a_s1 = i_porta_pin;
    st_nxt.a_s2 = st_r.a_s1;
    st_nxt.a_s3 = st_r.a_s2;
    a_settled = settle({8'h00, st_r.a_s2}, {8'h00, st_r.a_s3}, {8'h00, st_r.a_lvl});
    st_nxt.a_lvl = a_settled[15:0];
    st_nxt.a_prev = st_r.a_lvl;
    st_nxt.b_s1 = i_portb_pin;
    st_nxt.b_s2 = st_r.b_s1;
    st_nxt.b_s3 = st_r.b_s2;
    st_nxt.b_lvl = settle(st_r.b_s2, st_r.b_s3, st_r.b_lvl);
    st_nxt.b_prev = st_r.b_lvl;

    cond_a = detect(st_r.a_lvl, st_r.a_prev, st_r.porta_output_latch,
                    st_r.porta_irq_trigger_kind, st_r.porta_direction);
    cond_b = detect(fold(st_r.b_lvl), fold(st_r.b_prev), fold(st_r.portb_output_latch),
                    st_r.portb_irq_trigger_kind, fold(st_r.portb_direction));

    wr_hit = i_bus.wr;
    wclr_a = (wr_hit && i_bus.addr == `OFS_PORTA_IRQ_FLAGS) ? i_bus.wdata[15:0] : 16'h0000;
    wclr_b = (wr_hit && i_bus.addr == `OFS_PORTB_IRQ_FLAGS) ? i_bus.wdata[15:0] : 16'h0000;

    st_nxt.porta_irq_flags = (st_r.porta_irq_flags & ~wclr_a) | cond_a;
    st_nxt.portb_irq_flags = (st_r.portb_irq_flags & ~wclr_b) | cond_b;

    // register writes
    if (wr_hit) begin
      case (i_bus.addr)
        `OFS_PORTA_IRQ_ENABLE: st_nxt.porta_irq_enable = i_bus.wdata[15:0];
        `OFS_PORTB_IRQ_ENABLE: st_nxt.portb_irq_enable = i_bus.wdata[15:0];
        `OFS_PORTA_IRQ_TRIGGER_KIND: st_nxt.porta_irq_trigger_kind = i_bus.wdata[15:0];
        `OFS_PORTB_IRQ_TRIGGER_KIND: st_nxt.portb_irq_trigger_kind = i_bus.wdata[15:0];
        `OFS_IRQ_MASK: st_nxt.irq_mask = i_bus.wdata[1:0];
        `OFS_PORTA_DIRECTION: st_nxt.porta_direction = i_bus.wdata[15:0];
        `OFS_PORTB_DIRECTION: st_nxt.portb_direction = i_bus.wdata[23:0];
        `OFS_PORTA_OUTPUT_LATCH: st_nxt.porta_output_latch = i_bus.wdata[15:0];
        `OFS_PORTB_OUTPUT_LATCH: st_nxt.portb_output_latch = i_bus.wdata[23:0];
        // clear latch bits written as one
        `OFS_PORTA_OUTPUT_CLEAR: begin
          st_nxt.porta_output_latch = st_r.porta_output_latch & ~i_bus.wdata[15:0];
        end
        `OFS_PORTA_PULLUP_ENABLE: st_nxt.porta_pullup_enable = i_bus.wdata[15:0];
        `OFS_PORTA_PULLDOWN_OR_DRIVE: st_nxt.porta_pulldown_or_drive = i_bus.wdata[15:0];
        default: ;
      endcase
    end

    // port events: a flag newly set
    evt[`IRQ_BIT_PORTA] = |(st_nxt.porta_irq_flags & ~st_r.porta_irq_flags);
    evt[`IRQ_BIT_PORTB] = |(st_nxt.portb_irq_flags & ~st_r.portb_irq_flags);
    st_nxt.irq_status = st_r.irq_status | evt;
    if (wr_hit && i_bus.addr == `OFS_IRQ_CLEAR) begin
      st_nxt.irq_status = (st_r.irq_status & ~i_bus.wdata[1:0]) | evt;
    end

    // read data, one cycle after the strobe; upper bits zero
    st_nxt.rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `OFS_PORTA_IRQ_ENABLE: st_nxt.rdata = {16'h0000, st_r.porta_irq_enable};
        `OFS_PORTB_IRQ_ENABLE: st_nxt.rdata = {16'h0000, st_r.portb_irq_enable};
        `OFS_PORTA_IRQ_TRIGGER_KIND: st_nxt.rdata = {16'h0000, st_r.porta_irq_trigger_kind};
        `OFS_PORTB_IRQ_TRIGGER_KIND: st_nxt.rdata = {16'h0000, st_r.portb_irq_trigger_kind};
        `OFS_PORTA_IRQ_FLAGS: st_nxt.rdata = {16'h0000, st_r.porta_irq_flags};
        `OFS_PORTB_IRQ_FLAGS: st_nxt.rdata = {16'h0000, st_r.portb_irq_flags};
        `OFS_IRQ_STATUS: st_nxt.rdata = {30'h0000_0000, st_r.irq_status};
        `OFS_IRQ_MASK: st_nxt.rdata = {30'h0000_0000, st_r.irq_mask};
        `OFS_PORTA_DIRECTION: st_nxt.rdata = {16'h0000, st_r.porta_direction};
        `OFS_PORTA_INPUT_LEVEL: st_nxt.rdata = {16'h0000, st_r.a_lvl};
        `OFS_PORTA_OUTPUT_LATCH: st_nxt.rdata = {16'h0000, st_r.porta_output_latch};
        `OFS_PORTA_PULLUP_ENABLE: st_nxt.rdata = {16'h0000, st_r.porta_pullup_enable};
        `OFS_PORTA_PULLDOWN_OR_DRIVE: st_nxt.rdata = {16'h0000, st_r.porta_pulldown_or_drive};
        `OFS_PORTB_DIRECTION: st_nxt.rdata = {8'h00, st_r.portb_direction};
        `OFS_PORTB_INPUT_LEVEL: st_nxt.rdata = {8'h00, st_r.b_lvl};
        `OFS_PORTB_OUTPUT_LATCH: st_nxt.rdata = {8'h00, st_r.portb_output_latch};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // output pins drive the latch; input pins stay undriven
    st_nxt.a_pins.oe = st_nxt.porta_direction;
    st_nxt.a_pins.out = st_nxt.porta_output_latch & st_nxt.porta_direction;
    st_nxt.b_pins.oe = st_nxt.portb_direction;
    st_nxt.b_pins.out = st_nxt.portb_output_latch & st_nxt.portb_direction;
    st_nxt.a_pins.pu = st_nxt.porta_pullup_enable & ~st_nxt.porta_direction;
    st_nxt.a_pins.pd = st_nxt.porta_pulldown_or_drive & ~st_nxt.porta_direction;
    st_nxt.a_pins.drv20 = st_nxt.porta_pulldown_or_drive & st_nxt.porta_direction;

    // enabled flags raise the port request
    st_nxt.porta_irq = |(st_nxt.porta_irq_flags & st_nxt.porta_irq_enable);
    st_nxt.portb_irq = |(st_nxt.portb_irq_flags & st_nxt.portb_irq_enable);
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= `STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_porta = st_r.a_pins;
  assign o_portb = st_r.b_pins;
  assign o_porta_irq = st_r.porta_irq;
  assign o_portb_irq = st_r.portb_irq;
  assign o_irq = st_r.irq;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_irq_enable_gate: assert property (
    o_porta_irq == |(st_r.porta_irq_flags & st_r.porta_irq_enable))
    else $error("port a request does not follow enabled flags");

  a_edge_needs_change: assert property (
    (st_r.porta_irq_trigger_kind[0] && !st_r.porta_direction[0] && !wclr_a[0]
     && st_r.a_lvl[0] == st_r.a_prev[0] && !st_r.porta_irq_flags[0])
    |=> !st_r.porta_irq_flags[0])
    else $error("edge flag set without a pin change");

  a_flag_clear: assert property (
    (wclr_a[0] && cond_a[0] == 1'b0) |=> !st_r.porta_irq_flags[0])
    else $error("write one did not clear the flag");

  a_fold_pin22: assert property (
    (!st_r.portb_irq_trigger_kind[8] && !st_r.portb_direction[22]
     && st_r.portb_output_latch[22] && st_r.b_lvl[22]) |=> st_r.portb_irq_flags[8])
    else $error("port b pin 22 high level did not set flag bit 8");

  a_pin_drive: assert property (
    o_porta.oe == st_r.porta_direction
    && o_porta.out == (st_r.porta_output_latch & st_r.porta_direction))
    else $error("port a drive does not follow direction and latch");

  a_input_read: assert property (
    (i_bus.rd && i_bus.addr == `OFS_PORTA_INPUT_LEVEL)
    |=> o_rdata == {16'h0000, $past(st_r.a_lvl)})
    else $error("input level read mismatch");

  a_level_low_pol: assert property (
    (!st_r.porta_irq_trigger_kind[0] && !st_r.porta_direction[0]
     && !st_r.porta_output_latch[0] && !st_r.a_lvl[0]) |=> st_r.porta_irq_flags[0] [*1])
    else $error("low level did not set flag");

  a_latch_clear: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_OUTPUT_CLEAR && i_bus.wdata[0])
    |=> !st_r.porta_output_latch[0])
    else $error("output clear left the latch set");

  a_pull_select: assert property (
    o_porta.pd == (st_r.porta_pulldown_or_drive & ~st_r.porta_direction)
    && o_porta.drv20 == (st_r.porta_pulldown_or_drive & st_r.porta_direction))
    else $error("pull-down or drive select wrong");

  a_upper_zero: assert property (
    $past(i_bus.rd) && $past(i_bus.addr) == `OFS_PORTB_DIRECTION |-> o_rdata[31:24] == 8'h00)
    else $error("reserved read bits not zero");

  // register writes land on the edge after the strobe
  a_dir_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_DIRECTION)
    |=> o_porta.oe == $past(i_bus.wdata[15:0]))
    else $error("port a direction write did not reach the pins");

  a_portb_dir_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTB_DIRECTION)
    |=> o_portb.oe == $past(i_bus.wdata[23:0]))
    else $error("port b direction write did not reach the pins");

  a_latch_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_OUTPUT_LATCH)
    |=> st_r.porta_output_latch == $past(i_bus.wdata[15:0]))
    else $error("port a latch write lost");

  a_portb_latch_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTB_OUTPUT_LATCH)
    |=> st_r.portb_output_latch == $past(i_bus.wdata[23:0]))
    else $error("port b latch write lost");

  a_pullup_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_PULLUP_ENABLE)
    |=> st_r.porta_pullup_enable == $past(i_bus.wdata[15:0]))
    else $error("pull-up write lost");

  a_pd_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_PULLDOWN_OR_DRIVE)
    |=> st_r.porta_pulldown_or_drive == $past(i_bus.wdata[15:0]))
    else $error("pull-down or drive write lost");

  a_enable_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_IRQ_ENABLE)
    |=> st_r.porta_irq_enable == $past(i_bus.wdata[15:0]))
    else $error("interrupt enable write lost");

  a_trig_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_IRQ_TRIGGER_KIND)
    |=> st_r.porta_irq_trigger_kind == $past(i_bus.wdata[15:0]))
    else $error("trigger kind write lost");

  a_out_gated: assert property (
    !o_porta.oe[0] |-> !o_porta.out[0])
    else $error("input pin shows a drive level");

  a_clear_zero_keeps: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_OUTPUT_CLEAR && !i_bus.wdata[0])
    |=> st_r.porta_output_latch[0] == $past(st_r.porta_output_latch[0]))
    else $error("output clear of zero changed the latch");

  a_pullup_pin: assert property (
    o_porta.pu == (st_r.porta_pullup_enable & ~st_r.porta_direction))
    else $error("pull-up enable does not follow its register");

  a_pd_output_off: assert property (
    (o_porta.pd & o_porta.oe) == 16'h0000)
    else $error("pull-down on an output pin");

  a_drive_input_off: assert property (
    (o_porta.drv20 & ~o_porta.oe) == 16'h0000)
    else $error("strong drive on an input pin");

  a_flag_zero_write: assert property (
    (i_bus.wr && i_bus.addr == `OFS_PORTA_IRQ_FLAGS && !i_bus.wdata[0]
     && st_r.porta_irq_flags[0]) |=> st_r.porta_irq_flags[0])
    else $error("writing zero cleared a flag");

  a_set_wins: assert property (
    (wclr_a[0] && cond_a[0]) |=> st_r.porta_irq_flags[0])
    else $error("clear won over a new event");

  a_output_no_flag: assert property (
    st_r.porta_direction[0] |-> !cond_a[0])
    else $error("output pin raised an interrupt condition");

  a_level_high_pol: assert property (
    (!st_r.porta_irq_trigger_kind[8] && !st_r.porta_direction[8]
     && st_r.porta_output_latch[8] && st_r.a_lvl[8]) |=> st_r.porta_irq_flags[8])
    else $error("high level did not set flag");

  a_edge_rise: assert property (
    (st_r.porta_irq_trigger_kind[0] && !st_r.porta_direction[0] && st_r.porta_output_latch[0]
     && st_r.a_lvl[0] && !st_r.a_prev[0]) |=> st_r.porta_irq_flags[0])
    else $error("rising edge did not set flag");

  a_fold_pin23: assert property (
    (st_r.portb_irq_trigger_kind[9] && !st_r.portb_direction[23] && !st_r.portb_output_latch[23]
     && !st_r.b_lvl[23] && st_r.b_prev[23]) |=> st_r.portb_irq_flags[9])
    else $error("port b pin 23 falling edge did not set flag bit 9");

  a_level_reassert: assert property (
    (!st_r.portb_irq_trigger_kind[8] && !st_r.portb_direction[22] && !st_r.portb_output_latch[22]
     && !st_r.b_lvl[22] && wclr_b[8]) |=> st_r.portb_irq_flags[8])
    else $error("persisting level did not set the flag again");

  a_portb_irq_off: assert property (
    st_r.portb_irq_enable == 16'h0000 |-> !o_portb_irq)
    else $error("port b request with all enables clear");

  a_status_sticky: assert property (
    (st_r.irq_status[0] && !(i_bus.wr && i_bus.addr == `OFS_IRQ_CLEAR && i_bus.wdata[0]))
    |=> st_r.irq_status[0])
    else $error("status bit dropped without a clear");

  a_porta_upper_zero: assert property (
    ($past(i_bus.rd) && $past(i_bus.addr) == `OFS_PORTA_DIRECTION)
    |-> o_rdata[31:16] == 16'h0000)
    else $error("port a reserved read bits not zero");

  a_read_idle_zero: assert property (
    !$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data present without a read");

  a_portb_input_read: assert property (
    (i_bus.rd && i_bus.addr == `OFS_PORTB_INPUT_LEVEL)
    |=> o_rdata == {8'h00, $past(st_r.b_lvl)})
    else $error("port b input level read mismatch");

  c_edge_flag: cover property (
    st_r.porta_irq_trigger_kind[0] && $rose(st_r.porta_irq_flags[0]));
  c_fold_irq: cover property ($rose(st_r.portb_irq_flags[8]) ##1 o_portb_irq);
  c_level_refire: cover property (wclr_b[8] && cond_b[8]);
  c_set_over_clear: cover property (wclr_a[0] && cond_a[0]);
  c_top_irq: cover property ($rose(o_irq));

endmodule

// >>> hdl/gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
// register offsets on the 8-bit register port
`define OFS_PORTA_IRQ_ENABLE 8'h80
`define OFS_PORTB_IRQ_ENABLE 8'h84
`define OFS_PORTA_IRQ_TRIGGER_KIND 8'h88
`define OFS_PORTB_IRQ_TRIGGER_KIND 8'h8c
`define OFS_PORTA_IRQ_FLAGS 8'h90
`define OFS_PORTB_IRQ_FLAGS 8'h94
`define OFS_IRQ_STATUS 8'h98
`define OFS_IRQ_CLEAR 8'h9c
`define OFS_IRQ_MASK 8'h7c
`define OFS_PORTA_DIRECTION 8'ha0
`define OFS_PORTA_INPUT_LEVEL 8'ha4
`define OFS_PORTA_OUTPUT_LATCH 8'ha8
`define OFS_PORTA_OUTPUT_CLEAR 8'hac
`define OFS_PORTA_PULLUP_ENABLE 8'hb0
`define OFS_PORTA_PULLDOWN_OR_DRIVE 8'hb4
`define OFS_PORTB_DIRECTION 8'hc0
`define OFS_PORTB_INPUT_LEVEL 8'hc4
`define OFS_PORTB_OUTPUT_LATCH 8'hc8
// field positions
`define IRQ_BIT_PORTA 0
`define IRQ_BIT_PORTB 1
`define PORTB_FOLD_LO_PIN 22
`define PORTB_FOLD_HI_PIN 23
`define PORTB_FOLD_LO_BIT 8
`define PORTB_FOLD_HI_BIT 9
// reset value of the whole state, every register clears to zero
`define STATE_RESET '0
`endif

// >>> hdl/gpio_pkg.sv
package gpio_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] pu;
    logic [15:0] pd;
    logic [15:0] drv20;
  } porta_pins_t;

  typedef struct packed {
    logic [23:0] out;
    logic [23:0] oe;
  } portb_pins_t;

  typedef struct packed {
    logic [15:0] porta_direction;
    logic [15:0] porta_output_latch;
    logic [15:0] porta_pullup_enable;
    logic [15:0] porta_pulldown_or_drive;
    logic [15:0] porta_irq_enable;
    logic [15:0] porta_irq_trigger_kind;
    logic [15:0] porta_irq_flags;
    logic [23:0] portb_direction;
    logic [23:0] portb_output_latch;
    logic [15:0] portb_irq_enable;
    logic [15:0] portb_irq_trigger_kind;
    logic [15:0] portb_irq_flags;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [15:0] a_s1;
    logic [15:0] a_s2;
    logic [15:0] a_s3;
    logic [15:0] a_lvl;
    logic [15:0] a_prev;
    logic [23:0] b_s1;
    logic [23:0] b_s2;
    logic [23:0] b_s3;
    logic [23:0] b_lvl;
    logic [23:0] b_prev;
    logic [31:0] rdata;
    porta_pins_t a_pins;
    portb_pins_t b_pins;
    logic porta_irq;
    logic portb_irq;
    logic irq;
  } state_t;

endpackage

// >>> test/dual_port_gpio_with_pin_irq_test.sv
`timescale 1ns/1ps
`include "gpio_map.svh"
module dual_port_gpio_with_pin_irq_test import gpio_pkg::*;;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  bus_req_t i_bus = '0;
  logic [31:0] o_rdata;
  porta_pins_t o_porta;
  portb_pins_t o_portb;
  logic o_porta_irq, o_portb_irq, o_irq;
  logic [15:0] a_pin, a_en = '0, a_val = '0;
  logic [23:0] b_pin, b_en = '0, b_val = '0;
  int n_mismatch = 0;
  int n_checks = 0;
  always #50 i_clk = ~i_clk;
  gpio_dual_port i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_porta_pin(a_pin), .o_porta(o_porta), .i_portb_pin(b_pin), .o_portb(o_portb),
    .o_porta_irq(o_porta_irq), .o_portb_irq(o_portb_irq), .o_irq(o_irq));
  gpio_pin_model u_pins (.i_clk(i_clk), .i_porta(o_porta), .i_portb(o_portb),
    .i_a_en(a_en), .i_a_val(a_val), .i_b_en(b_en), .i_b_val(b_val),
    .o_a_pin(a_pin), .o_b_pin(b_pin));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_bus.addr <= a;
    i_bus.wdata <= d;
    i_bus.wr <= 1'b1;
    @(posedge i_clk);
    i_bus.wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_bus.addr <= a;
    i_bus.rd <= 1'b1;
    @(posedge i_clk);
    i_bus.rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [7:0] ofs [11];
    ofs = '{8'ha0, 8'ha8, 8'hb0, 8'hb4, 8'hc0, 8'hc8, 8'h80, 8'h84, 8'h88, 8'h8c, 8'h7c};
    foreach (ofs[i]) rchk(ofs[i], 32'h0);
    // input levels reset low and wandering pins never settle, so low-polarity level mode sets every flag bit of both ports at once
    rchk(8'h90, 32'h0000ffff);
    rchk(8'h94, 32'h0000ffff);
    rchk(8'h98, 32'h00000003);
    rchk(8'h40, 32'h0);
    chk(o_porta.oe, 16'h0);
  endtask
  task t_port;
    wr(8'ha0, 32'hffffffff);
    rchk(8'ha0, 32'h0000ffff);
    settle(1);
    chk(o_rdata, 32'h0);
    wr(8'ha0, 32'h000000ff);
    wr(8'ha8, 32'h00000f0f);
    wr(8'hb4, 32'h00003333);
    wr(8'hb0, 32'h00005555);
    settle(2);
    chk(o_porta.oe, 16'h00ff);
    chk(o_porta.out, 16'h000f);
    chk(o_porta.drv20, 16'h0033);
    chk(o_porta.pd, 16'h3300);
    chk(o_porta.pu, 16'h5500);
    wr(8'hc0, 32'hffffffff);
    rchk(8'hc0, 32'h00ffffff);
    wr(8'hc8, 32'hffa5a5a5);
    settle(2);
    chk(o_portb.out, 24'ha5a5a5);
    chk(o_portb.oe, 24'hffffff);
    rchk(8'hc8, 32'h00a5a5a5);
    wr(8'hc0, 32'h0);
  endtask
  task t_clear;
    wr(8'hac, 32'h00000303);
    rchk(8'ha8, 32'h00000c0c);
    wr(8'hac, 32'h0);
    rchk(8'ha8, 32'h00000c0c);
    rchk(8'hac, 32'h0);
  endtask
  task t_input;
    wr(8'ha0, 32'h0);
    wr(8'hb0, 32'h00000f00);
    wr(8'hb4, 32'h0000f000);
    @(posedge i_clk);
    a_en <= 16'h00ff;
    a_val <= 16'h00a5;
    b_en <= 24'hffffff;
    b_val <= 24'h5a5a5a;
    settle(6);
    rchk(8'ha4, 32'h00000fa5);
    rchk(8'hc4, 32'h005a5a5a);
  endtask
  task t_edge;
    @(posedge i_clk);
    a_val <= 16'h00a4;
    wr(8'h88, 32'h0000ffff);
    wr(8'ha8, 32'h00000001);
    settle(6);
    wr(8'h90, 32'h0000ffff);
    wr(8'h80, 32'h00000001);
    wr(8'h7c, 32'h00000001);
    wr(8'h9c, 32'h00000003);
    settle(2);
    chk(o_porta_irq, 1'b0);
    rchk(8'h90, 32'h0);
    @(posedge i_clk);
    a_val <= 16'h00a5;
    settle(6);
    rchk(8'h90, 32'h00000001);
    chk(o_porta_irq, 1'b1);
    chk(o_irq, 1'b1);
    rchk(8'h98, 32'h00000001);
    wr(8'h90, 32'h0);
    rchk(8'h90, 32'h00000001);
    wr(8'h90, 32'h00000001);
    rchk(8'h90, 32'h0);
    settle(2);
    chk(o_porta_irq, 1'b0);
    chk(o_irq, 1'b1);
    wr(8'h9c, 32'h00000001);
    settle(2);
    chk(o_irq, 1'b0);
    rchk(8'h98, 32'h0);
    @(posedge i_clk);
    a_val <= 16'h00a4;
    settle(6);
    rchk(8'h90, 32'h0);
  endtask
  task t_level;
    wr(8'h8c, 32'h0000feff);
    wr(8'hc8, 32'h0);
    settle(6);
    wr(8'h94, 32'h0000ffff);
    wr(8'h9c, 32'h00000003);
    rchk(8'h94, 32'h0);
    wr(8'h84, 32'h00000100);
    wr(8'h7c, 32'h00000002);
    @(posedge i_clk);
    b_val <= 24'h1a5a5a;
    settle(6);
    rchk(8'h94, 32'h00000100);
    chk(o_portb_irq, 1'b1);
    wr(8'h94, 32'h00000100);
    settle(2);
    rchk(8'h94, 32'h00000100);
    wr(8'h84, 32'h0);
    settle(2);
    chk(o_portb_irq, 1'b0);
    @(posedge i_clk);
    b_val <= 24'h9a5a5a;
    settle(6);
    @(posedge i_clk);
    b_val <= 24'h1a5a5a;
    settle(6);
    rchk(8'h94, 32'h00000300);
    rchk(8'h98, 32'h00000002);
    chk(o_irq, 1'b1);
    wr(8'h7c, 32'h00000001);
    settle(2);
    chk(o_irq, 1'b0);
    @(posedge i_clk);
    b_val <= 24'h5a5a5a;
    wr(8'hc8, 32'h00400000);
    settle(6);
    wr(8'h94, 32'h00000300);
    rchk(8'h94, 32'h00000100);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_port();
    t_clear();
    t_input();
    t_edge();
    t_level();
    conclude();
  end
  initial begin
    #(5000 * 100);
    n_mismatch++;
    conclude();
  end
endmodule

// >>> test/gpio_pin_model.sv
`timescale 1ns/1ps
module gpio_pin_model import gpio_pkg::*; (
  // clock
  input wire logic i_clk,
  // device pin controls
  input wire porta_pins_t i_porta,
  input wire portb_pins_t i_portb,
  // external drivers
  input wire logic [15:0] i_a_en,
  input wire logic [15:0] i_a_val,
  input wire logic [23:0] i_b_en,
  input wire logic [23:0] i_b_val,
  // resolved pin levels
  output logic [15:0] o_a_pin,
  output logic [23:0] o_b_pin
);
  // an undriven, unpulled pin wanders every cycle
  logic wander_r = 1'b0;
  always @(posedge i_clk) wander_r <= ~wander_r;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (i_porta.oe[i]) o_a_pin[i] = i_porta.out[i];
      else if (i_a_en[i]) o_a_pin[i] = i_a_val[i];
      else if (i_porta.pu[i]) o_a_pin[i] = 1'b1;
      else if (i_porta.pd[i]) o_a_pin[i] = 1'b0;
      else o_a_pin[i] = wander_r;
    end
    for (int i = 0; i < 24; i++) begin
      if (i_portb.oe[i]) o_b_pin[i] = i_portb.out[i];
      else if (i_b_en[i]) o_b_pin[i] = i_b_val[i];
      else o_b_pin[i] = wander_r;
    end
  end
endmodule
